// file: hdl/prs_pkg.sv
// shared constants and carrier types for the power rail sequencer
// assumes a single 100 MHz clock and a synchronous active-high reset
package prs_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 10;         // system clock period
  localparam int TICK_NS       = 1000000;    // one millisecond
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_OFF_MS  = 5;          // off time of one retry attempt

  // sizes
  localparam int RAILS     = 8;              // supply enables and monitor inputs
  localparam int GPOS      = 4;              // general outputs
  localparam int CHANS     = RAILS + GPOS;   // sequenced outputs in total
  localparam int ADC_BITS  = 10;             // converter resolution
  localparam int CNT_BITS  = 16;             // millisecond counters
  localparam int SEL_BITS  = 3;              // rail index width

  // reset values and special codes
  localparam logic [ADC_BITS-1:0] VOLT_RST      = 10'h000;
  localparam logic [CNT_BITS-1:0] CNT_RST       = 16'h0000;
  localparam logic [SEL_BITS-1:0] SEL_RST       = 3'h0;
  localparam logic [2:0]          TRIES_RST     = 3'h0;
  localparam logic [2:0]          RETRY_FOREVER = 3'h7;  // retry without limit

  // how a channel is switched on
  typedef enum logic [1:0] {
    PRS_ON_TIME,        // delay after reset or sequence event
    PRS_ON_PARENT_REG,  // delay after parent is regulated
    PRS_ON_PARENT_V,    // parent voltage reaches a level
    PRS_ON_NONE         // monitor only, never enabled
  } prs_on_mode_t;

  // what a rail fault does
  typedef enum logic [1:0] {
    PRS_ACT_IGNORE,     // no action
    PRS_ACT_LOG,        // flag only
    PRS_ACT_RETRY,      // off 5 ms, then on again
    PRS_ACT_SEQUENCE    // all off, then restart
  } prs_action_t;

  // per-channel sequencing configuration
  typedef struct packed {
    prs_on_mode_t          mode;        // switch-on trigger
    logic                  active_high; // enable polarity of supply rails; general outputs ignore it
    logic [SEL_BITS-1:0]   parent;      // parent rail index
    logic [CNT_BITS-1:0]   on_delay;    // ms before switch-on
    logic [ADC_BITS-1:0]   trig_level;  // parent voltage trigger
    logic [CNT_BITS-1:0]   off_delay;   // ms after shutdown command
  } prs_chan_cfg_t;

  // per-rail supervision configuration
  typedef struct packed {
    logic [ADC_BITS-1:0]   low_voltage_limit;   // lower regulation bound
    logic [ADC_BITS-1:0]   high_voltage_limit;  // upper regulation bound
    logic [CNT_BITS-1:0]   regulation_deadline; // ms to reach regulation
    prs_action_t           action;              // fault handling
    logic [2:0]            retries;             // attempts, 7 = forever
  } prs_rail_cfg_t;

  // per-rail status word
  typedef struct packed {
    logic enabled;      // enable asserted
    logic regulated;    // voltage inside limits
    logic startup_err;  // missed regulation deadline
    logic fault_seen;   // fault not set to ignore, since clear
    logic retrying;     // in a retry off period
  } prs_status_t;

endpackage : prs_pkg

// file: hdl/prs_ms_tick.sv
// millisecond tick generator for the power rail sequencer
// assumes one clock; reset is synchronous and active high
`timescale 1ns/100ps
module prs_ms_tick
  import prs_pkg::*;
#(
  parameter int CYCLES = 100000            // clock cycles per tick
) (
  input  wire logic clk,                   // system clock
  input  wire logic reset,                 // synchronous reset
  output logic      tick                   // one-cycle pulse each ms
);

  logic [31:0] cnt_q;                      // cycle counter
  logic [31:0] cnt_d;                      // next count
  logic        tick_d;                     // next tick

  // wrap the counter once per tick period
  always_comb begin
    tick_d = (cnt_q == 32'(CYCLES - 1));
    cnt_d  = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end

  // register count and tick
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule : prs_ms_tick

// file: hdl/prs_sequencer.sv
// power rail sequencer: rail and general output sequencing, monitor
// scanning, supervision, fault handling and status readback
// assumes an external converter driven through a channel select and a
// start pulse, whose ready and result pins are asynchronous to clk
`timescale 1ns/100ps

module prs_sequencer
  import prs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES     // clock cycles per ms tick
) (
  input  wire logic                  clk,                   // system clock
  input  wire logic                  reset,                 // sync reset
  input  wire prs_chan_cfg_t [CHANS-1:0] chan_cfg,          // per output
  input  wire prs_rail_cfg_t [RAILS-1:0] rail_cfg,          // per rail
  input  wire logic                  start_req,             // sequence event
  input  wire logic                  shutdown_req,          // shutdown cmd
  input  wire logic                  clear_status,          // clear flags
  output logic [RAILS-1:0]           supply_enable_out,     // rail enables
  output logic [GPOS-1:0]            general_output,        // gp outputs
  output logic [SEL_BITS-1:0]        adc_channel,           // monitor mux
  output logic                       adc_start,             // convert pulse
  input  wire logic                  adc_ready,             // pin, async
  input  wire logic [ADC_BITS-1:0]   voltage_monitor_input, // result pin
  input  wire logic [SEL_BITS-1:0]   rd_sel,                // readback rail
  output logic [ADC_BITS-1:0]        rd_voltage,            // latest voltage
  output prs_status_t                rd_status              // rail status
);

  // common millisecond tick
  logic tick;                                    // one pulse per ms

  prs_ms_tick #(
    .CYCLES (TICK_LEN)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  // converter pin synchronisers
  logic                rdy_s1_q, rdy_s2_q, rdy_s3_q;  // ready sync, edge
  logic [ADC_BITS-1:0] res_s1_q, res_s2_q;            // result sync

  always_ff @(posedge clk) begin
    if (reset) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      rdy_s3_q <= 1'b0;
      res_s1_q <= VOLT_RST;
      res_s2_q <= VOLT_RST;
    end else begin
      rdy_s1_q <= adc_ready;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      res_s1_q <= voltage_monitor_input;
      res_s2_q <= res_s1_q;
    end
  end

  // monitor scan state
  logic [SEL_BITS-1:0]             chan_q, chan_d;    // input under conversion
  logic                            busy_q, busy_d;    // conversion running
  logic                            start_q, start_d;  // start pulse
  logic [RAILS-1:0][ADC_BITS-1:0]  volt_q, volt_d;    // latest voltages
  logic [RAILS-1:0]                valid_q, valid_d;  // voltage sampled
  logic                            done;              // ready rising edge

  assign done        = rdy_s2_q & ~rdy_s3_q;
  assign adc_channel = chan_q;
  assign adc_start   = start_q;

  // round-robin scan: start, wait for ready, store, next input
  always_comb begin
    chan_d  = chan_q;
    busy_d  = busy_q;
    start_d = 1'b0;
    volt_d  = volt_q;
    valid_d = valid_q;
    if (!busy_q) begin                           // idle: start next
      start_d = 1'b1;
      busy_d  = 1'b1;
    end else if (done) begin                     // result ready
      volt_d[chan_q]  = res_s2_q;
      valid_d[chan_q] = 1'b1;
      chan_d          = chan_q + 3'h1;
      busy_d          = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chan_q  <= SEL_RST;
      busy_q  <= 1'b0;
      start_q <= 1'b0;
      volt_q  <= '0;
      valid_q <= '0;
    end else begin
      chan_q  <= chan_d;
      busy_q  <= busy_d;
      start_q <= start_d;
      volt_q  <= volt_d;
      valid_q <= valid_d;
    end
  end

  // regulation window per rail
  logic [RAILS-1:0] regulated;                   // inside limits

  always_comb begin
    for (int r = 0; r < RAILS; r++) begin
      regulated[r] = valid_q[r]
                   && volt_q[r] >= rail_cfg[r].low_voltage_limit
                   && volt_q[r] <= rail_cfg[r].high_voltage_limit;
    end
  end

  // global restart: sequence event or sequence-type fault
  typedef enum {
    PRS_S_IDLE,    // waiting for trigger
    PRS_S_DELAY,   // counting switch-on delay
    PRS_S_ON,      // enabled
    PRS_S_RETRY,   // off for one retry period
    PRS_S_DOWN,    // shutdown delay, still on
    PRS_S_OFF      // off until restart
  } prs_state_t;

  logic [RAILS-1:0] seq_hit;                     // sequence fault per rail
  logic             seq_q, seq_d;                // restart request
  logic             restart;                     // restart all channels
  logic [CHANS-1:0] en_q;                        // channel enabled

  assign seq_d   = |seq_hit;
  assign restart = start_req | seq_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
    end
  end

  // per-channel sequencing
  prs_state_t [CHANS-1:0]      st_q;              // channel state
  logic [CHANS-1:0][2:0]       tries_q;           // retry attempts used
  logic [RAILS-1:0]            up_q;              // reached regulation
  logic [RAILS-1:0]            serr_q;            // startup error
  logic [RAILS-1:0]            flt_q;             // fault seen

  genvar c;
  generate
    for (c = 0; c < CHANS; c++) begin : g_chan
      prs_state_t          st_d;                  // next state
      logic [CNT_BITS-1:0] cnt_q, cnt_d;          // ms counter
      logic [2:0]          tries_d;               // next attempts
      logic                en_d;                  // next enable
      logic                up_d, serr_d, flt_d;   // next rail flags
      logic                fault;                 // rail fault this cycle
      logic                miss;                  // deadline missed
      logic                seq_f;                 // sequence fault
      prs_chan_cfg_t       cf;                    // this channel's config
      logic [SEL_BITS-1:0] par;                   // parent index

      assign cf  = chan_cfg[c];
      assign par = cf.parent;

      // next state and counter for one channel
      always_comb begin
        st_d    = st_q[c];
        cnt_d   = tick ? cnt_q + 16'h0001 : cnt_q;
        tries_d = tries_q[c];
        up_d    = 1'b0;
        serr_d  = 1'b0;
        flt_d   = 1'b0;
        fault   = 1'b0;
        miss    = 1'b0;
        seq_f   = 1'b0;
        if (c < RAILS) begin
          up_d   = up_q[c % RAILS] | (st_q[c] == PRS_S_ON && regulated[c % RAILS]);
          serr_d = serr_q[c % RAILS] & ~clear_status;
          flt_d  = flt_q[c % RAILS] & ~clear_status;
          // fault: deadline missed before regulation, lost regulation, or a monitor-only rail outside its limits
          if (st_q[c] == PRS_S_ON) begin
            miss  = !up_q[c % RAILS] && tick
                  && cnt_q >= rail_cfg[c % RAILS].regulation_deadline;
            fault = miss || (up_q[c % RAILS] && !regulated[c % RAILS]);
          end else if (cf.mode == PRS_ON_NONE && st_q[c] == PRS_S_IDLE) begin
            fault = valid_q[c % RAILS] && !regulated[c % RAILS];
          end
          if (miss) begin
            serr_d = 1'b1;
          end
          if (fault && rail_cfg[c % RAILS].action != PRS_ACT_IGNORE) begin
            flt_d = 1'b1;
          end
          seq_f = fault && rail_cfg[c % RAILS].action == PRS_ACT_SEQUENCE;
        end
        unique case (st_q[c])
          PRS_S_IDLE: begin                      // wait for trigger
            cnt_d = CNT_RST;
            unique case (cf.mode)
              PRS_ON_TIME:       st_d = PRS_S_DELAY;
              PRS_ON_PARENT_REG: if (regulated[par]) st_d = PRS_S_DELAY;
              PRS_ON_PARENT_V:   if (valid_q[par] && volt_q[par] >= cf.trig_level)
                                   st_d = PRS_S_ON;
              PRS_ON_NONE:       st_d = PRS_S_IDLE;
            endcase
          end
          PRS_S_DELAY: begin                     // count switch-on delay
            if (cnt_q >= cf.on_delay) begin
              st_d  = PRS_S_ON;
              cnt_d = CNT_RST;
            end
          end
          PRS_S_ON: begin                        // supervise
            if (fault && rail_cfg[c % RAILS].action == PRS_ACT_RETRY) begin
              cnt_d = CNT_RST;
              if (rail_cfg[c % RAILS].retries == RETRY_FOREVER
                  || tries_q[c] < rail_cfg[c % RAILS].retries) begin
                st_d    = PRS_S_RETRY;
                tries_d = tries_q[c] + 3'h1;
              end else begin
                st_d = PRS_S_OFF;
              end
            end
          end
          PRS_S_RETRY: begin                     // enable off for 5 ms
            if (cnt_q >= CNT_BITS'(RETRY_OFF_MS)) begin
              st_d  = PRS_S_ON;
              cnt_d = CNT_RST;
            end
          end
          PRS_S_DOWN: begin                      // own shutdown delay
            if (cnt_q >= cf.off_delay) begin
              st_d = PRS_S_OFF;
            end
          end
          PRS_S_OFF: cnt_d = CNT_RST;            // hold off
        endcase
        // shutdown command: enabled outputs wait, others stop at once
        if (shutdown_req && st_q[c] != PRS_S_OFF && st_q[c] != PRS_S_DOWN) begin
          st_d  = (st_q[c] == PRS_S_ON) ? PRS_S_DOWN : PRS_S_OFF;
          cnt_d = CNT_RST;
        end
        // restart wins over shutdown: all off, sequence again
        if (restart) begin
          st_d    = PRS_S_IDLE;
          cnt_d   = CNT_RST;
          tries_d = TRIES_RST;
          up_d    = 1'b0;
        end
        if (up_q[c % RAILS] && c < RAILS && st_q[c] == PRS_S_ON) begin
          up_d = up_d;                           // kept while on
        end else if (c < RAILS && st_d != PRS_S_ON) begin
          up_d = 1'b0;                           // new attempt starts fresh
        end
        // enable is on only while on or counting shutdown delay
        en_d = (st_d == PRS_S_ON || st_d == PRS_S_DOWN)
             && cf.mode != PRS_ON_NONE;
      end

      // register one channel
      always_ff @(posedge clk) begin
        if (reset) begin
          st_q[c]    <= PRS_S_IDLE;
          cnt_q      <= CNT_RST;
          tries_q[c] <= TRIES_RST;
          en_q[c]    <= 1'b0;
        end else begin
          st_q[c]    <= st_d;
          cnt_q      <= cnt_d;
          tries_q[c] <= tries_d;
          en_q[c]    <= en_d;
        end
      end

      if (c < RAILS) begin : g_rail
        assign seq_hit[c] = seq_f;

        // rail flags: set wins over clear
        always_ff @(posedge clk) begin
          if (reset) begin
            up_q[c]   <= 1'b0;
            serr_q[c] <= 1'b0;
            flt_q[c]  <= 1'b0;
          end else begin
            up_q[c]   <= up_d;
            serr_q[c] <= serr_d;
            flt_q[c]  <= flt_d;
          end
        end

        // polarity applied to the registered enable
        assign supply_enable_out[c] = en_q[c] ~^ cf.active_high;
      end else begin : g_gpo
        assign general_output[c - RAILS] = en_q[c];
      end
    end
  endgenerate

  // readback of voltage and status
  logic [ADC_BITS-1:0] rdv_d;                    // next voltage word
  prs_status_t         rds_d;                    // next status word

  always_comb begin
    rdv_d             = volt_q[rd_sel];
    rds_d.enabled     = en_q[rd_sel];
    rds_d.regulated   = regulated[rd_sel];
    rds_d.startup_err = serr_q[rd_sel];
    rds_d.fault_seen  = flt_q[rd_sel];
    rds_d.retrying    = st_q[rd_sel] == PRS_S_RETRY;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_voltage <= VOLT_RST;
      rd_status  <= '0;
    end else begin
      rd_voltage <= rdv_d;
      rd_status  <= rds_d;
    end
  end

endmodule : prs_sequencer

// file: tb/prs_sequencer_properties.sv
// checker for the power rail sequencer top-level ports
// assumes one clock, synchronous active-high reset and static configuration
`timescale 1ns/100ps
module prs_sequencer_properties
  import prs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES            // cycles per ms tick
) (
  input wire logic                      clk,                   // system clock
  input wire logic                      reset,                 // sync reset
  input wire prs_chan_cfg_t [CHANS-1:0] chan_cfg,              // per output
  input wire prs_rail_cfg_t [RAILS-1:0] rail_cfg,              // per rail
  input wire logic                      start_req,             // sequence event
  input wire logic                      shutdown_req,          // shutdown cmd
  input wire logic                      clear_status,          // clear flags
  input wire logic [RAILS-1:0]          supply_enable_out,     // rail enables
  input wire logic [GPOS-1:0]           general_output,        // gp outputs
  input wire logic [SEL_BITS-1:0]       adc_channel,           // monitor mux
  input wire logic                      adc_start,             // convert pulse
  input wire logic                      adc_ready,             // result valid
  input wire logic [ADC_BITS-1:0]       voltage_monitor_input, // result pins
  input wire logic [SEL_BITS-1:0]       rd_sel,                // readback rail
  input wire logic [ADC_BITS-1:0]       rd_voltage,            // latest voltage
  input wire prs_status_t               rd_status              // rail status
);
  logic [SEL_BITS-1:0] rd_sel_q;  // rail behind the readback
  logic                sel_on_q;  // that rail's enable, one cycle late
  logic                none_on;   // a monitor-only rail is asserted
  logic [RAILS-1:0]    pol;       // asserted level of each enable

  // polarity vector and monitor-only watch
  always_comb begin
    none_on = 1'b0;
    for (int i = 0; i < RAILS; i++) begin
      pol[i] = chan_cfg[i].active_high;
      if (chan_cfg[i].mode == PRS_ON_NONE && supply_enable_out[i] == pol[i]) none_on = 1'b1;
    end
  end

  // readback reference, same latency as the status register
  always_ff @(posedge clk) begin
    rd_sel_q <= rd_sel;
    sel_on_q <= supply_enable_out[rd_sel] == chan_cfg[rd_sel].active_high;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("converter start longer than one cycle");
  a_chan_hold: assert property (adc_start |=> $stable(adc_channel) [*3])
    else $error("monitor select moved during conversion");
  a_scan_order: assert property ($rose(adc_ready) |-> ##[1:4]
    (adc_channel == $past(adc_channel) + 3'h1))
    else $error("monitor select did not step to the next input");
  a_scan_restart: assert property (adc_channel != $past(adc_channel) |-> ##[0:2] adc_start)
    else $error("no conversion started for the next input");
  a_reset_state: assert property ($fell(reset) |-> general_output == 4'h0 && !adc_start
    && adc_channel == 3'h0 && (supply_enable_out ^ pol) == 8'hff)
    else $error("outputs not cleared by reset");
  a_readback_enable: assert property (rd_status.enabled == sel_on_q)
    else $error("status enable bit differs from the rail enable");
  a_monitor_never_on: assert property (!none_on)
    else $error("monitor-only rail enable asserted");
  a_shutdown_hold: assert property (shutdown_req && !start_req |=>
    (general_output & $past(general_output)) == $past(general_output))
    else $error("general output dropped at once on shutdown");
  a_regulated_limits: assert property (($stable(rd_sel_q) && $stable(rd_voltage)) [*3]
    ##0 rd_status.regulated |-> rd_voltage >= rail_cfg[rd_sel_q].low_voltage_limit
    && rd_voltage <= rail_cfg[rd_sel_q].high_voltage_limit)
    else $error("rail reported regulated outside its limits");
endmodule : prs_sequencer_properties

bind prs_sequencer prs_sequencer_properties #(.TICK_LEN(TICK_LEN)) u_props (
  .clk(clk), .reset(reset), .chan_cfg(chan_cfg), .rail_cfg(rail_cfg),
  .start_req(start_req), .shutdown_req(shutdown_req), .clear_status(clear_status),
  .supply_enable_out(supply_enable_out), .general_output(general_output),
  .adc_channel(adc_channel), .adc_start(adc_start), .adc_ready(adc_ready),
  .voltage_monitor_input(voltage_monitor_input), .rd_sel(rd_sel),
  .rd_voltage(rd_voltage), .rd_status(rd_status));

// file: tb/prs_adc_model.sv
// behavioural model of the external converter behind the monitor mux
// assumes requests are one-cycle start pulses in the sequencer's clock domain
`timescale 1ns/100ps
module prs_adc_model
  import prs_pkg::*;
(
  input  wire logic                           clk,         // system clock
  input  wire logic                           reset,       // sync reset
  input  wire logic [SEL_BITS-1:0]            adc_channel, // selected input
  input  wire logic                           adc_start,   // convert pulse
  input  wire logic [RAILS-1:0][ADC_BITS-1:0] volts,       // levels at inputs
  output logic                                adc_ready,   // result valid
  output logic [ADC_BITS-1:0]                 result       // result pins
);
  logic [3:0] wait_q;  // cycles left in conversion
  logic       busy_q;  // conversion running
  logic       slow_q;  // alternates prompt and slow answers

  initial begin
    adc_ready = 1'b0;
    result    = 10'h155;
  end

  // conversion; result held while ready, inverted once released
  always @(posedge clk) begin
    if (reset) begin
      busy_q    <= 1'b0;
      adc_ready <= 1'b0;
      slow_q    <= 1'b0;
    end else if (adc_start) begin
      busy_q    <= 1'b1;
      adc_ready <= 1'b0;
      result    <= ~result;
      wait_q    <= slow_q ? 4'h7 : 4'h3;
      slow_q    <= ~slow_q;
    end else if (busy_q && wait_q == 4'h0) begin
      busy_q    <= 1'b0;
      adc_ready <= 1'b1;
      result    <= volts[adc_channel];  // one word per selected input
    end else if (busy_q) begin
      wait_q    <= wait_q - 4'h1;
    end
  end
endmodule : prs_adc_model

// file: tb/tb.sv
// self-checking bench for the power rail sequencer with a converter model
// assumes a 1 ms tick shortened to T clock cycles
`timescale 1ns/100ps
module tb;
  import prs_pkg::*;
  localparam int T = 10;                         // cycles per ms tick
  logic                             clk = 1'b0;     // system clock
  logic                             reset = 1'b1;   // sync reset
  prs_chan_cfg_t [CHANS-1:0]        chan_cfg;       // per-output setup
  prs_rail_cfg_t [RAILS-1:0]        rail_cfg;       // per-rail setup
  logic                             start_req, shutdown_req, clear_status; // commands
  logic [RAILS-1:0]                 supply_enable_out; // rail enables
  logic [GPOS-1:0]                  general_output;    // gp outputs
  logic [SEL_BITS-1:0]              adc_channel, rd_sel; // mux and readback select
  logic                             adc_start, adc_ready; // converter handshake
  logic [ADC_BITS-1:0]              mon, rd_voltage;   // result pins, readback
  prs_status_t                      rd_status;         // rail status
  logic [RAILS-1:0][ADC_BITS-1:0]   volts;             // supply levels
  int                               t_on [CHANS];      // first cycle seen on
  int                               t_off [CHANS];     // first cycle seen off
  int                               cyc, t0, mismatches, n_checks;
  prs_on_mode_t md [CHANS] = '{PRS_ON_TIME, PRS_ON_TIME, PRS_ON_PARENT_REG, PRS_ON_PARENT_V,
    PRS_ON_NONE, PRS_ON_TIME, PRS_ON_TIME, PRS_ON_TIME, PRS_ON_TIME, PRS_ON_TIME,
    PRS_ON_TIME, PRS_ON_TIME};
  int pol_a [CHANS] = '{1, 0, 1, 0, 1, 1, 0, 1, 1, 1, 1, 1};  // enable polarity
  int on_a [CHANS]  = '{2, 3, 1, 0, 0, 4, 5, 1, 1, 2, 3, 4};  // switch-on delay, ms
  int off_a [CHANS] = '{3, 1, 2, 4, 0, 5, 2, 1, 4, 3, 2, 1};  // shutdown delay, ms
  logic [ADC_BITS-1:0] nom [RAILS] = '{10'h200, 10'h180, 10'h200, 10'h280, 10'h200,
    10'h200, 10'h200, 10'h000};                              // level once on

  prs_sequencer #(.TICK_LEN(T)) u_dut (.clk(clk), .reset(reset), .chan_cfg(chan_cfg),
    .rail_cfg(rail_cfg), .start_req(start_req), .shutdown_req(shutdown_req),
    .clear_status(clear_status), .supply_enable_out(supply_enable_out),
    .general_output(general_output), .adc_channel(adc_channel), .adc_start(adc_start),
    .adc_ready(adc_ready), .voltage_monitor_input(mon), .rd_sel(rd_sel),
    .rd_voltage(rd_voltage), .rd_status(rd_status));
  prs_adc_model u_adc (.clk(clk), .reset(reset), .adc_channel(adc_channel),
    .adc_start(adc_start), .volts(volts), .adc_ready(adc_ready), .result(mon));

  always #5 clk = ~clk;

  // channel asserted, whatever its polarity
  function automatic logic is_on(int i);
    if (i < RAILS) return supply_enable_out[i] == chan_cfg[i].active_high;
    return general_output[i-RAILS];
  endfunction : is_on

  // a supply rises to its level only while enabled
  always_comb begin
    for (int i = 0; i < RAILS; i++)
      volts[i] = (supply_enable_out[i] == chan_cfg[i].active_high) ? nom[i] : 10'h000;
  end

  // edge times of every channel
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < CHANS; i++) begin
      if (is_on(i) && t_on[i] < 0) t_on[i] <= cyc;
      if (!is_on(i) && t_off[i] < 0) t_off[i] <= cyc;
    end
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // restart timing marks between edges
  task automatic arm();
    @(negedge clk);
    t0 = cyc;
    foreach (t_on[i]) t_on[i] = -1;
    foreach (t_off[i]) t_off[i] = -1;
  endtask : arm

  task automatic t_reset_values();
    @(negedge clk);
    chk("outputs in reset", {general_output, adc_start}, 5'h00);
    for (int i = 0; i < RAILS; i++) chk("enable in reset", is_on(i), 1'b0);
  endtask : t_reset_values

  task automatic t_time_mode();
    int e;
    repeat (7 * T) @(negedge clk);
    for (int i = 0; i < CHANS; i++) begin
      e = t_on[i] - t0 - on_a[i] * T;
      if (md[i] == PRS_ON_TIME) chk("on delay", e >= -T && e <= T + 3, 1'b1);
    end
    chk("retry off", is_on(7), 1'b0);
  endtask : t_time_mode

  task automatic t_parents();
    repeat (20 * T) @(negedge clk);
    chk("parent reg", t_on[2] > t_on[0] && t_on[2] - t_on[0] <= 2 * T + 150, 1'b1);
    chk("parent volt", t_on[3] > t_on[0] && t_on[3] - t_on[0] <= 150, 1'b1);
    chk("monitor only", t_on[4], -1);
    chk("retry spent", is_on(7), 1'b0);
  endtask : t_parents

  task automatic t_readback();
    logic rg;
    logic [4:0] ex;
    for (int i = 0; i < RAILS; i++) begin
      @(posedge clk) rd_sel <= i[SEL_BITS-1:0];
      repeat (3) @(negedge clk);
      rg = is_on(i) && volts[i] >= 10'h080 && volts[i] <= 10'h300;
      chk("voltage", rd_voltage, volts[i]);
      ex = {is_on(i), rg, i == 7, i == 4 || i == 7, 1'b0};
      chk("status", rd_status, ex);
    end
  endtask : t_readback

  task automatic t_shutdown();
    int e;
    @(posedge clk) shutdown_req <= 1'b1;
    @(posedge clk) shutdown_req <= 1'b0;
    arm();
    repeat (7 * T) @(negedge clk);
    for (int i = 0; i < CHANS; i++) begin
      e = t_off[i] - t0 - off_a[i] * T;
      if (i != 4) chk("off delay", e >= -T && e <= T + 3, 1'b1);
    end
  endtask : t_shutdown

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // the whole run is about 450 cycles; 5000 means a hang
  initial begin
    #50000;
    mismatches++;
    conclude();
  end

  initial begin
    {start_req, shutdown_req, clear_status} = 3'h0;
    rd_sel = SEL_RST;
    for (int i = 0; i < CHANS; i++)
      chan_cfg[i] = '{md[i], pol_a[i][0], SEL_RST, on_a[i][15:0], 10'h100, off_a[i][15:0]};
    for (int i = 0; i < RAILS; i++)
      rail_cfg[i] = '{10'h080, 10'h300, (i == 7) ? 16'h0002 : 16'h0064,
        (i == 7) ? PRS_ACT_RETRY : (i == 4) ? PRS_ACT_LOG : PRS_ACT_IGNORE,
        (i == 7) ? 3'h1 : TRIES_RST};  // rail 7 never regulates: one retry
    repeat (1) @(posedge clk);
    t_reset_values();
    @(posedge clk) reset <= 1'b0;
    arm();
    t_time_mode();
    t_parents();
    t_readback();
    t_shutdown();
    @(posedge clk) start_req <= 1'b1;
    @(posedge clk) start_req <= 1'b0;
    arm();
    t_time_mode();
    conclude();
  end
endmodule : tb
